// ### adcc_channel_start_control.v
`timescale 1ns/1ps
`include "adcc_regs.vh"

module adcc_channel_start_control (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        nrst_i,
    // register port
    input  wire [15:0] reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // trigger and interrupt
    input  wire        external_conversion_trigger_i,
    output reg         conversion_end_interrupt_o,
    // analog front end
    input  wire        comparator_high_i,
    output reg  [7:0]  trial_code_o,
    output reg  [2:0]  analog_channel_o,
    output reg         converter_active_o,
    // shared pin configuration
    input  wire        pullup_option_bit1_i,
    output wire [7:0]  analog_input_enable_o,
    output wire [7:0]  pullup_enable_o
);

    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_CONV = 2'd2;

    reg  [3:0]  analog_channel_count_select;
    reg  [7:0]  converter_mode_register;
    reg  [7:0]  conversion_result_register;
    reg  [7:0]  successive_approx_register;
    reg  [2:0]  bit_index;
    reg  [1:0]  state;
    reg  [`ADCC_STEP_CNT_W-1:0] step_cnt;
    reg         trig_meta;
    reg         trig_sync;
    reg         trig_prev;
    reg         cmp_meta;
    reg         cmp_sync;
    reg  [7:0]  next_sar;
    reg  [7:0]  final_code;

    wire        step_en;
    wire        trig_edge;
    wire        mode_enable;
    wire        mode_hw;
    wire        wr_mode;
    wire [7:0]  bit_mask;
    // reload count at full integer width, cut to the counter width on purpose
    wire [31:0] step_reload;

    assign mode_enable = converter_mode_register[`ADCC_MODE_ENABLE_BIT];
    assign mode_hw     = converter_mode_register[`ADCC_MODE_HWSTART_BIT];
    assign wr_mode     = reg_wr_i && (reg_addr_i == `ADCC_ADDR_MODE);
    assign trig_edge   = trig_sync && !trig_prev;
    assign bit_mask    = `ADCC_SAR_ONE << bit_index;
    assign step_reload = `ADCC_STEP_CYCLES - 1;

    // both pins come from outside the clock domain, two flops before use
    // trig_prev resets low like the idle pin, so no false edge follows reset
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
            cmp_meta  <= 1'b0;
            cmp_sync  <= 1'b0;
        end else begin
            trig_meta <= external_conversion_trigger_i;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
            cmp_meta  <= comparator_high_i;
            cmp_sync  <= cmp_meta;
        end
    end

    // register writes; input select is a byte-wide write, upper nibble dropped
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            analog_channel_count_select <= `ADCC_INPUT_SELECT_RST;
            converter_mode_register     <= `ADCC_MODE_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADCC_ADDR_INPUT_SELECT)
                analog_channel_count_select <= reg_wdata_i[`ADCC_COUNT_MSB:`ADCC_COUNT_LSB];
            // mode bits 5:4 and 0 are kept for read back but steer nothing here
            if (reg_addr_i == `ADCC_ADDR_MODE)
                converter_mode_register <= reg_wdata_i;
        end
    end

    // read data registered, one cycle after the read strobe; unmapped reads zero
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `ADCC_ADDR_INPUT_SELECT:
                    reg_rdata_o <= {`ADCC_UPPER_ZERO, analog_channel_count_select};
                `ADCC_ADDR_MODE:   reg_rdata_o <= converter_mode_register;
                `ADCC_ADDR_RESULT: reg_rdata_o <= conversion_result_register;
                default:           reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // per pin: analog when its index is below the count, else port with pull-up option
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            assign analog_input_enable_o[g] = (g < analog_channel_count_select);
            assign pullup_enable_o[g] = pullup_option_bit1_i &&
                                        !(g < analog_channel_count_select);
        end
    endgenerate

    // step divider; restarted with each conversion so the first trial gets a full step
    assign step_en = (state == ST_CONV) && (step_cnt == `ADCC_STEP_CNT_ZERO);

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            step_cnt <= `ADCC_STEP_CNT_ZERO;
        else if (state != ST_CONV || step_en)
            step_cnt <= step_reload[`ADCC_STEP_CNT_W-1:0];
        else
            step_cnt <= step_cnt - 1'b1;
    end

    // keep the decided bit, then try the next lower one
    always @* begin
        final_code = (successive_approx_register & ~bit_mask) |
                     (cmp_sync ? bit_mask : 8'h00);
        next_sar   = final_code | (bit_mask >> 1);
    end

    // conversion sequencer; a mode write restarts so the new setting takes effect
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state                      <= ST_IDLE;
            successive_approx_register <= `ADCC_SAR_RST;
            bit_index                  <= `ADCC_SAR_TOP_INDEX;
            conversion_result_register <= `ADCC_RESULT_RST;
            conversion_end_interrupt_o <= 1'b0;
        end else begin
            conversion_end_interrupt_o <= 1'b0;
            if (!mode_enable) begin
                state <= ST_IDLE;
            end else if (wr_mode) begin
                state <= ST_IDLE;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (mode_hw) begin
                            state <= ST_WAIT;
                        end else begin
                            state                      <= ST_CONV;
                            successive_approx_register <= `ADCC_SAR_FIRST_TRIAL;
                            bit_index                  <= `ADCC_SAR_TOP_INDEX;
                        end
                    end
                    ST_WAIT: begin
                        // edges seen while converting are dropped; only a new one here counts
                        if (trig_edge) begin
                            state                      <= ST_CONV;
                            successive_approx_register <= `ADCC_SAR_FIRST_TRIAL;
                            bit_index                  <= `ADCC_SAR_TOP_INDEX;
                        end
                    end
                    ST_CONV: begin
                        // compare result is three cycles old here, well inside one step
                        if (step_en) begin
                            if (bit_index == `ADCC_SAR_LAST_INDEX) begin
                                conversion_result_register <= final_code;
                                conversion_end_interrupt_o <= 1'b1;
                                if (mode_hw) begin
                                    state <= ST_WAIT;
                                end else begin
                                    successive_approx_register <= `ADCC_SAR_FIRST_TRIAL;
                                    bit_index <= `ADCC_SAR_TOP_INDEX;
                                end
                            end else begin
                                successive_approx_register <= next_sar;
                                bit_index <= bit_index - 1'b1;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // analog side outputs from flops
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trial_code_o       <= `ADCC_SAR_RST;
            analog_channel_o   <= 3'd0;
            converter_active_o <= 1'b0;
        end else begin
            trial_code_o       <= successive_approx_register;
            analog_channel_o   <= converter_mode_register[`ADCC_MODE_CHAN_MSB:`ADCC_MODE_CHAN_LSB];
            converter_active_o <= mode_enable;
        end
    end

endmodule

// ### adcc_regs.vh
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// register addresses on the register port
`define ADCC_ADDR_INPUT_SELECT  16'hFF84
`define ADCC_ADDR_MODE          16'hFF80
`define ADCC_ADDR_RESULT        16'hFF81

// reset values
`define ADCC_INPUT_SELECT_RST   4'h0
`define ADCC_MODE_RST           8'h00
`define ADCC_RESULT_RST         8'h00
`define ADCC_SAR_RST            8'h00

// mode register fields
`define ADCC_MODE_ENABLE_BIT    7
`define ADCC_MODE_HWSTART_BIT   6
`define ADCC_MODE_CHAN_MSB      3
`define ADCC_MODE_CHAN_LSB      1

// input select register fields
`define ADCC_COUNT_MSB          3
`define ADCC_COUNT_LSB          0
`define ADCC_UPPER_ZERO         4'h0

// successive approximation constants
`define ADCC_SAR_FIRST_TRIAL    8'h80
`define ADCC_SAR_TOP_INDEX      3'd7
`define ADCC_SAR_LAST_INDEX     3'd0
`define ADCC_SAR_ONE            8'h01

// one approximation step: time in ns, clock period in ns, derived cycle count
`define ADCC_STEP_NS            2000
`define ADCC_CLK_NS             4
`define ADCC_STEP_CYCLES        ((`ADCC_STEP_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_STEP_CNT_W         9
`define ADCC_STEP_CNT_ZERO      9'h000

`endif

// ### adcc_analog_model.sv
`timescale 1ns/1ps
// analog side: level on the selected input pin against the dac trial code
module adcc_analog_model (
    // dac trial code and input level
    input  wire [7:0] trial_code_i,
    input  wire [7:0] level_i,
    // comparator result
    output wire       comparator_high_o
);
    // ideal comparator; a real one needs the level steady across each step
    assign comparator_high_o = (level_i >= trial_code_i);
endmodule

// ### adcc_chk_assertions.sv
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_chk (
    // clock and reset
    input wire        core_clk_i,
    input wire        nrst_i,
    // register port
    input wire [15:0] reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    // converter
    input wire        conversion_end_interrupt_o,
    input wire [2:0]  analog_channel_o,
    input wire        converter_active_o,
    // pins
    input wire        pullup_option_bit1_i,
    input wire [7:0]  analog_input_enable_o,
    input wire [7:0]  pullup_enable_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // counts of 8 and up make every pin analog
    function automatic [7:0] therm(input [3:0] c);
        therm = c[3] ? 8'hFF : ((8'h01 << c) - 8'h01);
    endfunction
    // register port decodes
    wire sel_wr  = reg_wr_i && reg_addr_i == `ADCC_ADDR_INPUT_SELECT;
    wire mode_wr = reg_wr_i && reg_addr_i == `ADCC_ADDR_MODE;
    sequence sw_start;
        mode_wr && reg_wdata_i[7:6] == 2'b10;
    endsequence
    sequence settled_mode;
        mode_wr ##1 !mode_wr;
    endsequence
    // cycles since a software start, one at the edge after the write; another
    // mode write reloads or clears it and the end pulse clears it, so an aborted start never fires
    localparam int SW_MIN = 3990;
    localparam int SW_MAX = 4020;
    logic [12:0] sw_wait_cnt;
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            sw_wait_cnt <= 13'h0000;
        else if (mode_wr)
            sw_wait_cnt <= (reg_wdata_i[7:6] == 2'b10) ? 13'h0001 : 13'h0000;
        else if (conversion_end_interrupt_o)
            sw_wait_cnt <= 13'h0000;
        else if (sw_wait_cnt != 13'h0000 && sw_wait_cnt <= SW_MAX)
            sw_wait_cnt <= sw_wait_cnt + 13'h0001;
    end
    chk_pullup_mask: assert property (pullup_enable_o ==
        (pullup_option_bit1_i ? ~analog_input_enable_o : 8'h00)) else $error("pull-up bad");
    chk_enable_contig: assert property (
        ((analog_input_enable_o + 8'h01) & analog_input_enable_o) == 8'h00) else $error("gap");
    chk_count_write: assert property (sel_wr |=>
        analog_input_enable_o == therm($past(reg_wdata_i[3:0]))) else $error("count map");
    chk_upper_zero: assert property ((reg_rd_i && reg_addr_i == `ADCC_ADDR_INPUT_SELECT)
        |=> reg_rdata_o[7:4] == 4'h0) else $error("upper bits");
    chk_irq_single: assert property (conversion_end_interrupt_o |=>
        !conversion_end_interrupt_o) else $error("irq too long");
    chk_stop_quiet: assert property ((mode_wr && !reg_wdata_i[7]) |=>
        !conversion_end_interrupt_o [*8]) else $error("irq after stop");
    chk_mode_follow: assert property (settled_mode |=>
        converter_active_o == $past(reg_wdata_i[7], 2) &&
        analog_channel_o == $past(reg_wdata_i[3:1], 2)) else $error("mode outputs");
    chk_sw_convert: assert property (sw_wait_cnt <= SW_MAX)
        else $error("no conversion end");
    chk_sw_early: assert property (conversion_end_interrupt_o && sw_wait_cnt != 13'h0000
        |-> sw_wait_cnt >= SW_MIN) else $error("conversion end too early");
    chk_sw_active: assert property (sw_start |-> ##2 converter_active_o)
        else $error("converter not active");
endmodule
bind adcc_channel_start_control adcc_chk u_chk (.core_clk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .conversion_end_interrupt_o,
    .analog_channel_o, .converter_active_o, .pullup_option_bit1_i,
    .analog_input_enable_o, .pullup_enable_o);

// ### testbench.sv
`timescale 1ns/1ps
`include "adcc_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
    localparam [15:0] sel_a = `ADCC_ADDR_INPUT_SELECT;
    localparam [15:0] res_a = `ADCC_ADDR_RESULT;
    localparam [15:0] mod_a = `ADCC_ADDR_MODE;
    logic        core_clk = 0, nrst = 0, wr = 0, rd = 0, trig = 0, opt = 1;
    logic [15:0] addr = 0;
    logic [7:0]  wdata = 0, level = 0;
    logic [7:0]  lv [3] = '{8'hA5, 8'h00, 8'hFF};
    wire  [7:0]  rdata, trial, aen, puen;
    wire  [2:0]  chan;
    wire         irq, cmp, act;
    int          fail_count = 0, cmp_count = 0, i, n, c;
    adcc_channel_start_control dut (.core_clk_i(core_clk), .nrst_i(nrst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .external_conversion_trigger_i(trig), .conversion_end_interrupt_o(irq),
        .comparator_high_i(cmp), .trial_code_o(trial), .analog_channel_o(chan),
        .converter_active_o(act), .pullup_option_bit1_i(opt),
        .analog_input_enable_o(aen), .pullup_enable_o(puen));
    adcc_analog_model u_ana (.trial_code_i(trial), .level_i(level), .comparator_high_o(cmp));
    // 250 MHz core clock
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    function [7:0] therm(input [3:0] k);
        therm = k[3] ? 8'hFF : (8'h01 << k) - 8'h01;
    endfunction
    // each access opens one falling edge after the call, so a strobe released
    // by the previous access never rises again in the same time step
    task wreg(input [15:0] a, input [7:0] d);
        @(negedge core_clk);
        addr  = a;
        wdata = d;
        wr    = 1;
        @(negedge core_clk) wr = 0;
    endtask
    // read data is registered: compared at the falling edge after the strobe edge
    task rreg(input [15:0] a, input [7:0] e);
        @(negedge core_clk);
        addr = a;
        rd   = 1;
        @(negedge core_clk) rd = 0;
        `CHK(rdata, e)
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait for one conversion end pulse
    task wait_irq;
        for (i = 0; i < 5000 && irq !== 1'b1; i++) @(negedge core_clk);
        if (irq !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            conclude;
        end else begin
            @(negedge core_clk);
        end
    endtask
    // every cycle that is not a clean low counts, so an unknown pulse fails too
    task quiet(input int cyc);
        n = 0;
        repeat (cyc) @(negedge core_clk) if (irq !== 1'b0) n++;
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        nrst = 1;
        @(negedge core_clk);
        rreg(sel_a, 8'h00);
        `CHK(puen, 8'hFF)
        `CHK(aen, 8'h00)
        $display("test reset done");
        // upper nibble set on purpose: it must be dropped; the unmapped read
        // follows a nonzero read for counts 1 to 8 so that a stale value would show
        for (c = 0; c <= 8; c++) begin
            wreg(sel_a, 8'hF0 | c[7:0]);
            rreg(sel_a, c[7:0]);
            rreg(16'hFF90, 8'h00);
            `CHK(aen, therm(c[3:0]))
            `CHK(puen, ~therm(c[3:0]))
        end
        // three analog pins: option off drops every pull-up, option on only port pins
        wreg(sel_a, 8'h03);
        opt = 0;
        @(negedge core_clk) `CHK(puen, 8'h00)
        opt = 1;
        @(negedge core_clk) `CHK(puen, 8'hF8)
        wreg(sel_a, 8'h08);
        $display("test channel count done");
        level = lv[0];
        wreg(mod_a, 8'h8A);
        for (c = 0; c < 3; c++) begin
            wait_irq;
            if (c < 2) level = lv[c + 1];
            rreg(res_a, lv[c]);
        end
        `CHK(chan, 3'd5)
        `CHK(act, 1'b1)
        wreg(mod_a, 8'h00);
        @(negedge core_clk) `CHK(act, 1'b0)
        quiet(5000);
        `CHK(n, 0)
        $display("test software start done");
        level = 8'h5A;
        wreg(mod_a, 8'hC4);
        @(negedge core_clk) `CHK(chan, 3'd2)
        quiet(5000);
        `CHK(n, 0)
        trig = 1;
        repeat (10) @(negedge core_clk);
        trig = 0;
        wait_irq;
        rreg(res_a, 8'h5A);
        quiet(5000);
        `CHK(n, 0)
        $display("test hardware start done");
        wreg(mod_a, 8'h8A);
        repeat (100) @(negedge core_clk);
        nrst = 0;
        repeat (3) @(negedge core_clk);
        nrst = 1;
        @(negedge core_clk);
        rreg(sel_a, 8'h00);
        `CHK(act, 1'b0)
        quiet(5000);
        `CHK(n, 0)
        $display("test reset in run done");
        conclude;
    end
endmodule
